// >>> logic/fac_consts.svh
`ifndef FAC_CONSTS_SVH
`define FAC_CONSTS_SVH

`define FAC_ADDR_W 8
`define FAC_DATA_W 8

`define FAC_ADDR_CPF_LO 8'h30
`define FAC_ADDR_CPF_MID 8'h31
`define FAC_ADDR_CPF_HI 8'h32
`define FAC_ADDR_STEP_LO 8'h34
`define FAC_ADDR_STEP_MID 8'h35
`define FAC_ADDR_STEP_HI 8'h36
`define FAC_ADDR_BIT_DIV 8'h38
`define FAC_ADDR_CH_DIV 8'h39
`define FAC_ADDR_CTRL 8'h3A

`define FAC_CPF_W 18
`define FAC_STEP_W 22
`define FAC_DIV_W 6
`define FAC_CTRL_W 4
`define FAC_ACC_W 23
`define FAC_CORR_W 16

`define FAC_BIT_LOOP_OPEN 3
`define FAC_BIT_VREF_SEL 2
`define FAC_BIT_CH_PHASE 1
`define FAC_BIT_BIT_PHASE 0

`define FAC_RST_BYTE 8'h00
`define FAC_CORR_ONE 16'h0001
`define FAC_CORR_MAX 16'h7FFF
`define FAC_CORR_MIN 16'h8000

`endif

// >>> logic/fac_pkg.sv
`default_nettype none
`include "fac_consts.svh"
package fac_pkg;
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [`FAC_ADDR_W-1:0] addr;
        logic [`FAC_DATA_W-1:0] data;
    } facRegReq_t;
endpackage
`default_nettype wire

// >>> logic/fac_audio_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "fac_consts.svh"
module fac_audio_clock_gen (
    input wire logic clock,
    input wire logic srst,
    input wire fac_pkg::facRegReq_t regReq,
    output logic [`FAC_DATA_W-1:0] regRdData,
    input wire logic intVertPulse,
    input wire logic expansionVerticalRef,
    input wire logic audioMasterClockIn,
    output logic audioMasterClock,
    output logic audioBitClock,
    output logic audioChannelClock
);
    import fac_pkg::*;

    logic [`FAC_CPF_W-1:0] cyclesPerFieldCount_q;
    logic [`FAC_STEP_W-1:0] nominalStepValue_q;
    logic [`FAC_DIV_W-1:0] bitClockDivider_q;
    logic [`FAC_DIV_W-1:0] channelClockDivider_q;
    logic [`FAC_CTRL_W-1:0] ctrl_q;
    logic [`FAC_DATA_W-1:0] rdData_q;
    logic mclkSync1_q, mclkSync2_q, mclkPrev_q;
    logic xrvSync1_q, xrvSync2_q, xrvPrev_q;
    logic [`FAC_ACC_W-1:0] acc_q;
    logic [`FAC_CPF_W-1:0] fieldCnt_q;
    logic [`FAC_CORR_W-1:0] corr_q;
    logic [`FAC_DIV_W-1:0] bitCnt_q, chCnt_q;
    logic bitClk_q, chClk_q;

    // Register decode
    wire logic wrCpfLo = regReq.wrEn && regReq.addr == `FAC_ADDR_CPF_LO;
    wire logic wrCpfMid = regReq.wrEn && regReq.addr == `FAC_ADDR_CPF_MID;
    wire logic wrCpfHi = regReq.wrEn && regReq.addr == `FAC_ADDR_CPF_HI;
    wire logic wrStepLo = regReq.wrEn && regReq.addr == `FAC_ADDR_STEP_LO;
    wire logic wrStepMid = regReq.wrEn && regReq.addr == `FAC_ADDR_STEP_MID;
    wire logic wrStepHi = regReq.wrEn && regReq.addr == `FAC_ADDR_STEP_HI;
    wire logic wrBitDiv = regReq.wrEn && regReq.addr == `FAC_ADDR_BIT_DIV;
    wire logic wrChDiv = regReq.wrEn && regReq.addr == `FAC_ADDR_CH_DIV;
    wire logic wrCtrl = regReq.wrEn && regReq.addr == `FAC_ADDR_CTRL;

    // Unused upper bits of each register read back as zero
    logic [`FAC_DATA_W-1:0] rdMux;
    always_comb begin
        if (regReq.addr == `FAC_ADDR_CPF_LO) begin
            rdMux = cyclesPerFieldCount_q[7:0];
        end else if (regReq.addr == `FAC_ADDR_CPF_MID) begin
            rdMux = cyclesPerFieldCount_q[15:8];
        end else if (regReq.addr == `FAC_ADDR_CPF_HI) begin
            rdMux = {6'h00, cyclesPerFieldCount_q[17:16]};
        end else if (regReq.addr == `FAC_ADDR_STEP_LO) begin
            rdMux = nominalStepValue_q[7:0];
        end else if (regReq.addr == `FAC_ADDR_STEP_MID) begin
            rdMux = nominalStepValue_q[15:8];
        end else if (regReq.addr == `FAC_ADDR_STEP_HI) begin
            rdMux = {2'h0, nominalStepValue_q[21:16]};
        end else if (regReq.addr == `FAC_ADDR_BIT_DIV) begin
            rdMux = {2'h0, bitClockDivider_q};
        end else if (regReq.addr == `FAC_ADDR_CH_DIV) begin
            rdMux = {2'h0, channelClockDivider_q};
        end else if (regReq.addr == `FAC_ADDR_CTRL) begin
            rdMux = {4'h0, ctrl_q};
        end else begin
            rdMux = `FAC_RST_BYTE;
        end
    end

    wire logic audioLoopOpen = ctrl_q[`FAC_BIT_LOOP_OPEN];
    wire logic verticalRefSelect = ctrl_q[`FAC_BIT_VREF_SEL];
    wire logic channelClockPhase = ctrl_q[`FAC_BIT_CH_PHASE];
    wire logic bitClockPhase = ctrl_q[`FAC_BIT_BIT_PHASE];

    // Edges of the synchronised master clock input
    wire logic mRise = mclkSync2_q && !mclkPrev_q;
    wire logic mFall = !mclkSync2_q && mclkPrev_q;
    wire logic mEdgeSel = bitClockPhase ? mRise : mFall;
    wire logic bitToggle = mEdgeSel && bitCnt_q >= bitClockDivider_q;
    // A bit clock toggle from low is a rising edge, from high a falling one
    wire logic bitEdgeSel = bitToggle && (channelClockPhase ? !bitClk_q : bitClk_q);
    wire logic chToggle = bitEdgeSel && chCnt_q >= channelClockDivider_q;

    wire logic xrvRise = xrvSync2_q && !xrvPrev_q;
    wire logic fieldPulse = verticalRefSelect ? xrvRise : intVertPulse;

    // Correction is a signed trim added to the nominal step
    wire logic [`FAC_ACC_W-1:0] effStep = {1'b0, nominalStepValue_q}
        + {{(`FAC_ACC_W-`FAC_CORR_W){corr_q[`FAC_CORR_W-1]}}, corr_q};
    wire logic [`FAC_ACC_W-1:0] acc_d = acc_q + effStep;
    wire logic amRise = acc_d[`FAC_ACC_W-1] && !acc_q[`FAC_ACC_W-1];
    wire logic [`FAC_CPF_W-1:0] fieldCnt_d = fieldPulse ? {{(`FAC_CPF_W-1){1'b0}}, amRise}
        : fieldCnt_q + {{(`FAC_CPF_W-1){1'b0}}, amRise};
    wire logic tooFew = fieldCnt_q < cyclesPerFieldCount_q;
    wire logic tooMany = fieldCnt_q > cyclesPerFieldCount_q;
    wire logic [`FAC_CORR_W-1:0] corr_d =
        audioLoopOpen ? {`FAC_CORR_W{1'b0}} :
        !fieldPulse ? corr_q :
        (tooFew && corr_q != `FAC_CORR_MAX) ? corr_q + `FAC_CORR_ONE :
        (tooMany && corr_q != `FAC_CORR_MIN) ? corr_q - `FAC_CORR_ONE : corr_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            cyclesPerFieldCount_q <= {`FAC_CPF_W{1'b0}};
            nominalStepValue_q <= {`FAC_STEP_W{1'b0}};
            bitClockDivider_q <= {`FAC_DIV_W{1'b0}};
            channelClockDivider_q <= {`FAC_DIV_W{1'b0}};
            ctrl_q <= {`FAC_CTRL_W{1'b0}};
            rdData_q <= `FAC_RST_BYTE;
        end else begin
            if (wrCpfLo) cyclesPerFieldCount_q[7:0] <= regReq.data;
            if (wrCpfMid) cyclesPerFieldCount_q[15:8] <= regReq.data;
            if (wrCpfHi) cyclesPerFieldCount_q[17:16] <= regReq.data[1:0];
            if (wrStepLo) nominalStepValue_q[7:0] <= regReq.data;
            if (wrStepMid) nominalStepValue_q[15:8] <= regReq.data;
            if (wrStepHi) nominalStepValue_q[21:16] <= regReq.data[5:0];
            if (wrBitDiv) bitClockDivider_q <= regReq.data[5:0];
            if (wrChDiv) channelClockDivider_q <= regReq.data[5:0];
            if (wrCtrl) ctrl_q <= regReq.data[3:0];
            if (regReq.rdEn) rdData_q <= rdMux;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mclkSync1_q <= 1'b0;
            mclkSync2_q <= 1'b0;
            mclkPrev_q <= 1'b0;
            xrvSync1_q <= 1'b0;
            xrvSync2_q <= 1'b0;
            xrvPrev_q <= 1'b0;
        end else begin
            mclkSync1_q <= audioMasterClockIn;
            mclkSync2_q <= mclkSync1_q;
            mclkPrev_q <= mclkSync2_q;
            xrvSync1_q <= expansionVerticalRef;
            xrvSync2_q <= xrvSync1_q;
            xrvPrev_q <= xrvSync2_q;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            acc_q <= {`FAC_ACC_W{1'b0}};
            fieldCnt_q <= {`FAC_CPF_W{1'b0}};
            corr_q <= {`FAC_CORR_W{1'b0}};
        end else begin
            acc_q <= acc_d;
            fieldCnt_q <= fieldCnt_d;
            corr_q <= corr_d;
        end
    end

    // Counts restart when a divider is lowered below the running count
    always_ff @(posedge clock) begin
        if (srst) begin
            bitCnt_q <= {`FAC_DIV_W{1'b0}};
            chCnt_q <= {`FAC_DIV_W{1'b0}};
            bitClk_q <= 1'b0;
            chClk_q <= 1'b0;
        end else begin
            if (mEdgeSel) bitCnt_q <= bitToggle ? {`FAC_DIV_W{1'b0}} : bitCnt_q + 6'h01;
            if (bitToggle) bitClk_q <= !bitClk_q;
            if (bitEdgeSel) chCnt_q <= chToggle ? {`FAC_DIV_W{1'b0}} : chCnt_q + 6'h01;
            if (chToggle) chClk_q <= !chClk_q;
        end
    end

    assign regRdData = rdData_q;
    assign audioMasterClock = acc_q[`FAC_ACC_W-1];
    assign audioBitClock = bitClk_q;
    assign audioChannelClock = chClk_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_cpf_high;
        wrCpfHi ##1 !srst |-> cyclesPerFieldCount_q[17:16] == $past(regReq.data[1:0]);
    endproperty
    a_cpf_high: assert property (p_cpf_high) else $error("cycles per field top bits not stored");

    property p_step_high;
        wrStepHi |=> nominalStepValue_q[21:16] == $past(regReq.data[5:0]);
    endproperty
    a_step_high: assert property (p_step_high) else $error("nominal step top bits not stored");

    property p_bit_div;
        $changed(bitClk_q) |-> $past(bitCnt_q) >= $past(bitClockDivider_q) && $past(mEdgeSel);
    endproperty
    a_bit_div: assert property (p_bit_div) else $error("bit clock toggled before divider count");

    property p_ch_div;
        $changed(chClk_q) |-> $past(chCnt_q) >= $past(channelClockDivider_q) && $changed(bitClk_q);
    endproperty
    a_ch_div: assert property (p_ch_div) else $error("channel clock toggled off its count");

    property p_open_loop;
        audioLoopOpen ##1 audioLoopOpen |-> corr_q == {`FAC_CORR_W{1'b0}};
    endproperty
    a_open_loop: assert property (p_open_loop) else $error("open loop still corrects");

    property p_vref_sel;
        verticalRefSelect && !xrvRise && !audioLoopOpen |=> corr_q == $past(corr_q) || audioLoopOpen;
    endproperty
    a_vref_sel: assert property (p_vref_sel) else $error("correction without selected reference");

    property p_ch_phase;
        $changed(chClk_q) |-> ($past(channelClockPhase) ? $rose(bitClk_q) : $fell(bitClk_q));
    endproperty
    a_ch_phase: assert property (p_ch_phase) else $error("channel clock on wrong bit clock edge");

    property p_bit_phase;
        $changed(bitClk_q) |-> ($past(bitClockPhase) ? $past(mRise) : $past(mFall));
    endproperty
    a_bit_phase: assert property (p_bit_phase) else $error("bit clock on wrong master edge");

    property p_lock_up;
        fieldPulse && !audioLoopOpen && !wrCtrl && tooFew && corr_q != `FAC_CORR_MAX
            |=> corr_q == $past(corr_q) + `FAC_CORR_ONE;
    endproperty
    a_lock_up: assert property (p_lock_up) else $error("locked loop did not raise step");

    property p_lock_down;
        fieldPulse && !audioLoopOpen && tooMany && corr_q != `FAC_CORR_MIN
            |=> corr_q == $past(corr_q) - `FAC_CORR_ONE;
    endproperty
    a_lock_down: assert property (p_lock_down) else $error("locked loop did not lower step");

    c_bit_toggle: cover property (bitToggle);
    c_ch_toggle: cover property (chToggle);
    c_locked_field: cover property (fieldPulse && !audioLoopOpen && tooMany);
endmodule
`default_nettype wire

// >>> verif/fac_audio_partner.sv
`timescale 1ns/1ps
`default_nettype none
module fac_audio_partner (
    input wire logic audioChannelClock,
    output logic audioMasterClockIn,
    output logic [15:0] channelFrames
);
    // Converter clock runs free; the offset keeps its phase away from the system clock edges
    initial begin
        audioMasterClockIn = 1'b0;
        #7.3;
        forever #100 audioMasterClockIn = ~audioMasterClockIn;
    end
    initial channelFrames = 16'h0000;
    always @(posedge audioChannelClock) channelFrames <= channelFrames + 16'h0001;
endmodule
`default_nettype wire

// >>> verif/fac_audio_clock_gen_test.sv
`timescale 1ns/1ps
`default_nettype none
module fac_audio_clock_gen_test;
    import fac_pkg::*;
    logic clock, srst, intVertPulse, expansionVerticalRef, audioMasterClockIn;
    logic audioMasterClock, audioBitClock, audioChannelClock;
    facRegReq_t regReq;
    logic [7:0] regRdData;
    logic [15:0] channelFrames, rises;
    logic intOn, pinOn, mon, bPh, cPh, bPrimed, cPrimed, aOld, mOld, bOld, cOld;
    logic [7:0] mEdges, bEdges;
    logic [7:0] bitDiv = 8'h01;
    logic [7:0] chDiv = 8'h02;
    int failures, tests_run, cycles;
    logic [23:0] rows [11] = '{24'h30A5A5, 24'h315A5A, 24'h32FF03, 24'h34C3C3, 24'h353C3C, 24'h36FF3F,
        24'h38FF3F, 24'h39FF3F, 24'h3AFF0F, 24'h33FF00, 24'h37FF00};
    logic [15:0] setup [6] = '{16'h30FF, 16'h31FF, 16'h3203, 16'h3400, 16'h3500, 16'h3610};

    fac_audio_clock_gen i_fac_audio_clock_gen (.clock(clock), .srst(srst), .regReq(regReq),
        .regRdData(regRdData), .intVertPulse(intVertPulse), .expansionVerticalRef(expansionVerticalRef),
        .audioMasterClockIn(audioMasterClockIn), .audioMasterClock(audioMasterClock),
        .audioBitClock(audioBitClock), .audioChannelClock(audioChannelClock));
    fac_audio_partner i_fac_audio_partner (.audioChannelClock(audioChannelClock),
        .audioMasterClockIn(audioMasterClockIn), .channelFrames(channelFrames));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #2 regReq = {2'b10, a, d};
        @(posedge clock);
        #2 regReq = '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clock);
        #2 regReq = {2'b01, a, 8'h00};
        @(posedge clock);
        #2 regReq = '0;
        q = regRdData;
    endtask

    // Master rises are counted over 8192 cycles; at step 2^20 that is exactly 1024 without correction
    task automatic measure(input logic [7:0] ctrl, input logic useInt, input logic usePin, input int pre);
        wr(8'h3A, ctrl);
        intOn = useInt;
        pinOn = usePin;
        repeat (pre) @(posedge clock);
        rises = 16'h0000;
        repeat (8192) @(posedge clock);
    endtask

    always @(posedge clock) begin
        #2;
        cycles++;
        intVertPulse = intOn && !intVertPulse;
        expansionVerticalRef = pinOn && cycles[1];
        if (audioMasterClock && !aOld) rises++;
        if (mon && audioMasterClockIn != mOld && audioMasterClockIn == bPh) mEdges++;
        if (mon && audioBitClock != bOld) begin
            bEdges++;
            if (bPrimed) begin
                chk(audioMasterClockIn, bPh);
                chk(mEdges, bitDiv + 8'h01);
            end
            bPrimed = 1'b1;
            mEdges = 8'h00;
        end
        if (mon && audioChannelClock != cOld) begin
            if (cPrimed) begin
                chk(audioBitClock, cPh);
                chk(bEdges, 2 * (chDiv + 8'h01));
            end
            cPrimed = 1'b1;
            bEdges = 8'h00;
        end
        if (!mon) {bPrimed, cPrimed} = 2'b00;
        {aOld, mOld, bOld, cOld} = {audioMasterClock, audioMasterClockIn, audioBitClock, audioChannelClock};
        if (cycles == 90000) begin
            failures++;
            close_out;
        end
    end

    initial begin
        logic [7:0] v;
        logic [15:0] f0;
        regReq = '0;
        srst = 1'b1;
        {intVertPulse, expansionVerticalRef, intOn, pinOn, mon} = 5'b00000;
        {failures, tests_run, cycles} = {32'h0, 32'h0, 32'h0};
        repeat (19) @(posedge clock);
        #2;
        chk(regRdData, 8'h00);
        chk({audioMasterClock, audioBitClock, audioChannelClock}, 3'h0);
        @(posedge clock);
        #2 srst = 1'b0;
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], v);
            chk(v, rows[i][7:0]);
        end
        $display("test registers done");
        wr(8'h38, bitDiv);
        wr(8'h39, chDiv);
        f0 = channelFrames;
        for (int p = 0; p < 4; p++) begin
            {cPh, bPh} = p[1:0];
            wr(8'h3A, {6'h00, p[1:0]});
            repeat (300) @(posedge clock);
            mon = 1'b1;
            repeat (800) @(posedge clock);
            mon = 1'b0;
        end
        chk(channelFrames > f0, 1'b1);
        $display("test clock phases done");
        foreach (setup[i]) wr(setup[i][15:8], setup[i][7:0]);
        measure(8'h08, 1'b1, 1'b0, 64);
        chk(rises, 16'h0400);
        measure(8'h04, 1'b1, 1'b0, 64);
        chk(rises, 16'h0400);
        measure(8'h00, 1'b1, 1'b0, 8192);
        chk(rises >= 16'h0402, 1'b1);
        measure(8'h08, 1'b0, 1'b0, 64);
        chk(rises, 16'h0400);
        measure(8'h04, 1'b0, 1'b1, 8192);
        chk(rises >= 16'h0402, 1'b1);
        $display("test master clock done");
        // Target of zero makes every field with a master rise too long, so the trim must go negative
        wr(8'h30, 8'h00);
        wr(8'h31, 8'h00);
        wr(8'h32, 8'h00);
        wr(8'h3A, 8'h08);
        measure(8'h00, 1'b1, 1'b0, 8192);
        chk(rises <= 16'h03FF, 1'b1);
        $display("test lock down done");
        intOn = 1'b0;
        pinOn = 1'b0;
        #2 srst = 1'b1;
        repeat (2) @(posedge clock);
        #2;
        chk(regRdData, 8'h00);
        chk({audioMasterClock, audioBitClock, audioChannelClock}, 3'h0);
        srst = 1'b0;
        rd(8'h36, v);
        chk(v, 8'h00);
        $display("test second reset done");
        close_out;
    end
endmodule
`default_nettype wire
